// ### rtl/dag_addr_fmt.sv
// Direct-data address and short-immediate value formatting
`timescale 1ns/1ps
`default_nettype none
`include "dag_defs.svh"
module dag_addr_fmt (
  input wire logic [15:0] page_base,
  input wire logic [`DAG_OFFSET_W-1:0] offset,
  input wire logic [15:0] imm,
  output logic [15:0] direct_addr,
  output logic [15:0] short_val
);
  // Low five bits of the page base are ignored
  assign direct_addr = {page_base[15:`DAG_PAGE_LSB], offset};
  // Short field is zero extended
  assign short_val = {{(16 - `DAG_SHORT_W){1'b0}}, imm[`DAG_SHORT_W-1:0]};
endmodule : dag_addr_fmt
`default_nettype wire

// ### rtl/dag_postmod.sv
// Pointer postmodification adder with modulo wraparound
`timescale 1ns/1ps
`default_nettype none
module dag_postmod (
  input wire logic [15:0] ptr,
  input wire dag_pkg::dag_step_t step,
  input wire logic [15:0] inc_i,
  input wire logic [15:0] inc_j,
  input wire logic [15:0] inc_k,
  input wire logic [15:0] begin_addr,
  input wire logic [15:0] end_addr,
  input wire logic wrap_ok,
  output logic [15:0] ptr_next,
  output logic wrapped
);
  import dag_pkg::*;
  always_comb begin
    // Zero end address disables wraparound
    wrapped = wrap_ok && (end_addr != 16'h0000) && (ptr == end_addr) && (step == DAG_STEP_INC);
    case (step)
      DAG_STEP_ZERO: ptr_next = ptr;
      DAG_STEP_INC: ptr_next = ptr + 16'h0001;
      DAG_STEP_DEC: ptr_next = ptr - 16'h0001;
      DAG_STEP_PLUS2: ptr_next = ptr + 16'h0002;
      DAG_STEP_I: ptr_next = ptr + inc_i;
      DAG_STEP_J: ptr_next = ptr + inc_j;
      DAG_STEP_K: ptr_next = ptr + inc_k;
      default: ptr_next = ptr;
    endcase
    // Modulo wrap: at the end address a +1 step reloads the begin address, flagged by wrapped
    if (wrapped) begin
      ptr_next = begin_addr;
    end
  end
endmodule : dag_postmod
`default_nettype wire

// ### rtl/dag_top.sv
// Data address generator: pointers, postmodify, modulo, compound swap, direct, immediates
`timescale 1ns/1ps
`default_nettype none
`include "dag_defs.svh"
module dag_top #(
  parameter int ADDR_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic op_valid,
  output logic op_ready,
  input wire dag_pkg::dag_op_t op_kind,
  input wire logic [2:0] op_ptr,
  input wire dag_pkg::dag_mod_t op_mod,
  input wire dag_pkg::dag_swap_t op_swap,
  input wire logic [3:0] op_reg,
  input wire logic [15:0] op_imm,
  input wire logic [`DAG_OFFSET_W-1:0] op_offset,
  input wire logic [15:0] op_wdata,
  input wire logic [15:0] mem_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic mem_xspace,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic ext_wr,
  output logic [3:0] ext_sel,
  output logic [15:0] ext_wdata,
  input wire logic [3:0] peek_sel,
  output logic [15:0] peek_data,
  output logic modulo_active
);
  import dag_pkg::*;

  localparam int ISSUE_CYC = (`DAG_INSTR_NS / `DAG_CLK_NS) < 1 ? 1 : (`DAG_INSTR_NS / `DAG_CLK_NS);

  generate
    if (ADDR_W != `DAG_WORD_W) begin : g_bad_width
      $error("dag_top supports only a 16-bit address");
    end
    if (ISSUE_CYC != 1) begin : g_bad_clock
      $error("dag_top issues accesses in one clock");
    end
  endgenerate

  typedef struct packed {
    dag_state_t st;
    logic [3:0][15:0] yptr;
    logic [15:0] pt;
    logic [15:0] inc_i;
    logic [15:0] inc_j;
    logic [15:0] inc_k;
    logic [15:0] rb;
    logic [15:0] re;
    logic [15:0] ybase;
    logic [15:0] temp;
    logic [2:0] cur_ptr;
    dag_swap_t sw;
    logic [3:0] dest;
    logic op_ready;
    logic mem_req;
    logic mem_we;
    logic mem_xspace;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic ext_wr;
    logic [3:0] ext_sel;
    logic [15:0] ext_wdata;
    logic [15:0] peek;
    logic mod_on;
  } dag_core_t;

  dag_core_t state_reg;
  dag_core_t state_next;
  logic [15:0] pm_ptr;
  dag_step_t pm_step;
  logic pm_wrap_ok;
  logic [15:0] pm_next;
  logic pm_wrapped;
  logic [15:0] direct_addr;
  logic [15:0] short_val;
  logic [15:0] src_val;
  logic [15:0] cur_val;
  logic accept;

  // Register read by code; codes outside the unit come from the caller
  function automatic logic [15:0] get_reg(input dag_core_t s, input logic [3:0] code, input logic [15:0] ext);
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3: get_reg = s.yptr[code[1:0]];
      `DAG_REG_PT: get_reg = s.pt;
      `DAG_REG_I: get_reg = s.inc_i;
      `DAG_REG_J: get_reg = s.inc_j;
      `DAG_REG_K: get_reg = s.inc_k;
      `DAG_REG_RB: get_reg = s.rb;
      `DAG_REG_RE: get_reg = s.re;
      `DAG_REG_YBASE: get_reg = s.ybase;
      default: get_reg = ext;
    endcase
  endfunction : get_reg

  // Register write by code; outside codes become a one-cycle write strobe
  function automatic dag_core_t put_reg(input dag_core_t s, input logic [3:0] code, input logic [15:0] v);
    dag_core_t o;
    o = s;
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3: o.yptr[code[1:0]] = v;
      `DAG_REG_PT: o.pt = v;
      `DAG_REG_I: o.inc_i = v;
      `DAG_REG_J: o.inc_j = v;
      `DAG_REG_K: o.inc_k = v;
      `DAG_REG_RB: o.rb = v;
      `DAG_REG_RE: o.re = v;
      `DAG_REG_YBASE: o.ybase = v;
      default: begin
        o.ext_wr = 1'b1;
        o.ext_sel = code;
        o.ext_wdata = v;
      end
    endcase
    put_reg = o;
  endfunction : put_reg

  dag_postmod u_postmod (
    .ptr(pm_ptr),
    .step(pm_step),
    .inc_i(state_reg.inc_i),
    .inc_j(state_reg.inc_j),
    .inc_k(state_reg.inc_k),
    .begin_addr(state_reg.rb),
    .end_addr(state_reg.re),
    .wrap_ok(pm_wrap_ok),
    .ptr_next(pm_next),
    .wrapped(pm_wrapped)
  );

  dag_addr_fmt u_addr_fmt (
    .page_base(state_reg.ybase),
    .offset(op_offset),
    .imm(op_imm),
    .direct_addr(direct_addr),
    .short_val(short_val)
  );

  assign accept = op_valid && state_reg.op_ready && (state_reg.st == DAG_ST_IDLE);
  assign src_val = get_reg(state_reg, op_reg, op_wdata);
  assign cur_val = get_reg(state_reg, {1'b0, state_reg.cur_ptr}, 16'h0000);

  // Step selection for the single postmodify adder
  always_comb begin
    pm_wrap_ok = 1'b0;
    pm_step = DAG_STEP_ZERO;
    if (state_reg.st == DAG_ST_SWAP_RD) begin
      pm_ptr = cur_val;
      case (state_reg.sw)
        DAG_SWAP_ZERO_THEN_PLUS: begin
          pm_step = DAG_STEP_INC;
          pm_wrap_ok = 1'b1;
        end
        DAG_SWAP_MINUS_THEN_PLUS_TWO: pm_step = DAG_STEP_PLUS2;
        DAG_SWAP_STEPREG_PAIR: pm_step = DAG_STEP_K;
        default: pm_step = DAG_STEP_ZERO;
      endcase
    end else begin
      pm_ptr = get_reg(state_reg, {1'b0, op_ptr}, 16'h0000);
      if (op_kind == DAG_OP_SWAP) begin
        case (op_swap)
          DAG_SWAP_PLUS_THEN_ZERO: begin
            pm_step = DAG_STEP_INC;
            pm_wrap_ok = 1'b1;
          end
          DAG_SWAP_MINUS_THEN_PLUS_TWO: pm_step = DAG_STEP_DEC;
          DAG_SWAP_STEPREG_PAIR: pm_step = DAG_STEP_J;
          default: pm_step = DAG_STEP_ZERO;
        endcase
      end else if (op_ptr == `DAG_PTR_PT) begin
        // X space knows only ++ and ++i; no modulo there
        pm_step = (op_mod == DAG_MOD_STEP) ? DAG_STEP_I : DAG_STEP_INC;
      end else begin
        case (op_mod)
          DAG_MOD_INC: begin
            pm_step = DAG_STEP_INC;
            pm_wrap_ok = 1'b1;
          end
          DAG_MOD_DEC: pm_step = DAG_STEP_DEC;
          DAG_MOD_STEP: pm_step = DAG_STEP_J;
          default: pm_step = DAG_STEP_ZERO;
        endcase
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.mem_req = 1'b0;
    state_next.mem_we = 1'b0;
    state_next.ext_wr = 1'b0;
    case (state_reg.st)
      DAG_ST_IDLE: begin
        if (accept) begin
          state_next.cur_ptr = (op_ptr == `DAG_PTR_PT) ? op_ptr : {1'b0, op_ptr[1:0]};
          state_next.dest = op_reg;
          state_next.sw = op_swap;
          case (op_kind)
            DAG_OP_RD_IND, DAG_OP_WR_IND: begin
              state_next.mem_req = 1'b1;
              state_next.mem_we = (op_kind == DAG_OP_WR_IND);
              state_next.mem_xspace = (op_ptr == `DAG_PTR_PT);
              state_next.mem_addr = pm_ptr;
              state_next.mem_wdata = src_val;
              state_next = put_reg(state_next, {1'b0, state_next.cur_ptr}, pm_next);
              if (op_kind == DAG_OP_RD_IND) begin
                state_next.st = DAG_ST_RD_WAIT;
              end
            end
            DAG_OP_SWAP: begin
              state_next.temp = src_val;
              state_next.mem_req = 1'b1;
              state_next.mem_xspace = 1'b0;
              state_next.mem_addr = pm_ptr;
              state_next = put_reg(state_next, {1'b0, state_next.cur_ptr}, pm_next);
              state_next.st = DAG_ST_SWAP_RD;
            end
            DAG_OP_RD_DIR, DAG_OP_WR_DIR: begin
              state_next.mem_req = 1'b1;
              state_next.mem_we = (op_kind == DAG_OP_WR_DIR);
              state_next.mem_xspace = 1'b0;
              state_next.mem_addr = direct_addr;
              state_next.mem_wdata = src_val;
              if (op_kind == DAG_OP_RD_DIR) begin
                state_next.st = DAG_ST_RD_WAIT;
              end
            end
            DAG_OP_IMM_SHORT: begin
              // Page base and outside registers are not short-immediate targets
              if (op_reg != `DAG_REG_YBASE && op_reg <= `DAG_REG_YBASE) begin
                state_next = put_reg(state_next, op_reg, short_val);
              end
            end
            DAG_OP_IMM_LONG: state_next.st = DAG_ST_IMM2;
            default: state_next.st = DAG_ST_IDLE;
          endcase
        end
      end
      DAG_ST_RD_WAIT: begin
        state_next = put_reg(state_next, state_reg.dest, mem_rdata);
        state_next.st = DAG_ST_IDLE;
      end
      DAG_ST_SWAP_RD: begin
        // Old register value goes back through the already stepped pointer
        state_next = put_reg(state_next, state_reg.dest, mem_rdata);
        state_next.mem_req = 1'b1;
        state_next.mem_we = 1'b1;
        state_next.mem_addr = pm_ptr;
        state_next.mem_wdata = state_reg.temp;
        state_next = put_reg(state_next, {1'b0, state_reg.cur_ptr}, pm_next);
        state_next.st = DAG_ST_IDLE;
      end
      DAG_ST_IMM2: begin
        if (op_valid) begin
          state_next = put_reg(state_next, state_reg.dest, op_imm);
          state_next.st = DAG_ST_IDLE;
        end
      end
      default: state_next.st = DAG_ST_IDLE;
    endcase
    state_next.op_ready = (state_next.st == DAG_ST_IDLE) || (state_next.st == DAG_ST_IMM2);
    state_next.peek = get_reg(state_next, peek_sel, 16'h0000);
    state_next.mod_on = (state_next.re != 16'h0000);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.re <= `DAG_END_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign op_ready = state_reg.op_ready;
  assign mem_req = state_reg.mem_req;
  assign mem_we = state_reg.mem_we;
  assign mem_xspace = state_reg.mem_xspace;
  assign mem_addr = state_reg.mem_addr;
  assign mem_wdata = state_reg.mem_wdata;
  assign ext_wr = state_reg.ext_wr;
  assign ext_sel = state_reg.ext_sel;
  assign ext_wdata = state_reg.ext_wdata;
  assign peek_data = state_reg.peek;
  assign modulo_active = state_reg.mod_on;

  logic acc_ind_y;
  logic acc_no_self;
  assign acc_ind_y = accept && (op_kind == DAG_OP_RD_IND || op_kind == DAG_OP_WR_IND) && !op_ptr[2];
  assign acc_no_self = (op_kind == DAG_OP_WR_IND) || (op_reg != {2'b00, op_ptr[1:0]});

  AST_ISSUE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (op_kind == DAG_OP_RD_IND || op_kind == DAG_OP_RD_DIR) |-> ##ISSUE_CYC mem_req && !mem_we ##1 op_ready)
    else $error("read access not issued in one cycle");
  AST_PLAIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ind_y && acc_no_self && op_mod == DAG_MOD_NONE |=> cur_val == $past(pm_ptr) && mem_addr == $past(pm_ptr))
    else $error("plain indirect changed the pointer");
  AST_INC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ind_y && acc_no_self && op_mod == DAG_MOD_INC && !pm_wrapped |=> cur_val == mem_addr + 16'h0001)
    else $error("postincrement wrong");
  AST_DEC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ind_y && acc_no_self && op_mod == DAG_MOD_DEC |=> cur_val == mem_addr - 16'h0001)
    else $error("postdecrement wrong");
  AST_STEP_J: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ind_y && acc_no_self && op_mod == DAG_MOD_STEP |=> cur_val == mem_addr + $past(state_reg.inc_j))
    else $error("j step wrong");
  AST_STEP_I: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && op_kind == DAG_OP_WR_IND && op_ptr == `DAG_PTR_PT && op_mod == DAG_MOD_STEP
    |=> mem_xspace && state_reg.pt == mem_addr + $past(state_reg.inc_i))
    else $error("i step wrong");
  AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ind_y && acc_no_self && op_mod == DAG_MOD_INC && state_reg.re != 16'h0000 && pm_ptr == state_reg.re
    |=> cur_val == $past(state_reg.rb))
    else $error("modulo reload missing");
  AST_NO_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ind_y && acc_no_self && op_mod == DAG_MOD_INC && state_reg.re == 16'h0000 |=> cur_val == mem_addr + 16'h0001)
    else $error("modulo active with zero end");
  AST_RESET_END: assert property (@(posedge clk_sys)
    !rst_n |=> state_reg.re == 16'h0000 && !modulo_active)
    else $error("end register not cleared by reset");
  AST_DIRECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && op_kind == DAG_OP_RD_DIR |=> mem_req && mem_addr == $past(direct_addr) && !mem_xspace)
    else $error("direct address wrong");
  AST_SWAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && op_kind == DAG_OP_SWAP |=> mem_req && !mem_we ##1 mem_req && mem_we && mem_wdata == $past(src_val, 2))
    else $error("swap sequence wrong");
  AST_LONG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && op_kind == DAG_OP_IMM_LONG |=> op_ready && !mem_req && state_reg.st == DAG_ST_IMM2)
    else $error("long immediate did not wait for second word");
  AST_SHORT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && op_kind == DAG_OP_IMM_SHORT |=> !mem_req && !ext_wr && state_reg.ybase == $past(state_reg.ybase))
    else $error("short immediate did more than load");
endmodule : dag_top
`default_nettype wire

// ### shared/dag_defs.svh
// Constants of the data address generator: register codes, fields, reset values, timing
`ifndef DAG_DEFS_SVH
`define DAG_DEFS_SVH
`define DAG_WORD_W 16
`define DAG_OFFSET_W 5
`define DAG_PAGE_LSB 5
`define DAG_SHORT_W 9
`define DAG_REG_R0 4'h0
`define DAG_REG_R3 4'h3
`define DAG_REG_PT 4'h4
`define DAG_REG_I 4'h5
`define DAG_REG_J 4'h6
`define DAG_REG_K 4'h7
`define DAG_REG_RB 4'h8
`define DAG_REG_RE 4'h9
`define DAG_REG_YBASE 4'hA
`define DAG_PTR_PT 3'h4
`define DAG_REG_RESET 16'h0000
`define DAG_END_RESET 16'h0000
`define DAG_INSTR_NS 33
`define DAG_CLK_NS 25
`endif

// ### shared/dag_pkg.sv
// Types shared by the data address generator modules
package dag_pkg;
  typedef enum logic [2:0] {
    DAG_OP_NOP, DAG_OP_RD_IND, DAG_OP_WR_IND, DAG_OP_SWAP,
    DAG_OP_RD_DIR, DAG_OP_WR_DIR, DAG_OP_IMM_SHORT, DAG_OP_IMM_LONG
  } dag_op_t;
  typedef enum logic [1:0] {DAG_MOD_NONE, DAG_MOD_INC, DAG_MOD_DEC, DAG_MOD_STEP} dag_mod_t;
  typedef enum logic [1:0] {
    DAG_SWAP_ZERO_THEN_PLUS, DAG_SWAP_PLUS_THEN_ZERO, DAG_SWAP_MINUS_THEN_PLUS_TWO, DAG_SWAP_STEPREG_PAIR
  } dag_swap_t;
  typedef enum logic [2:0] {
    DAG_STEP_ZERO, DAG_STEP_INC, DAG_STEP_DEC, DAG_STEP_PLUS2, DAG_STEP_I, DAG_STEP_J, DAG_STEP_K
  } dag_step_t;
  typedef enum {DAG_ST_IDLE, DAG_ST_RD_WAIT, DAG_ST_SWAP_RD, DAG_ST_IMM2} dag_state_t;
endpackage : dag_pkg

// ### tb/dag_mem_model.sv
// Data memory model on the far side of the address generator
`timescale 1ns/1ps
`default_nettype none
module dag_mem_model (
  input wire logic clk_sys,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_xspace,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [15:0] store [logic [16:0]];
  initial mem_rdata = 16'h0000;
  // Read data stands one cycle; an idle bus toggles so stale data never looks valid
  always @(posedge clk_sys) begin
    if (mem_req && mem_we) begin
      store[{mem_xspace, mem_addr}] = mem_wdata;
    end
  end
  // Put up mid-cycle, so the data stands at the edge that ends the read cycle
  always @(negedge clk_sys) begin
    if (mem_req && !mem_we) begin
      mem_rdata <= store.exists({mem_xspace, mem_addr}) ? store[{mem_xspace, mem_addr}] : (mem_addr ^ 16'h5A3C);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : dag_mem_model
`default_nettype wire

// ### tb/tb_data_address_generation.sv
// Self-checking bench for the data address generator
`timescale 1ns/1ps
`default_nettype none
`include "dag_defs.svh"
module tb_data_address_generation;
  import dag_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  dag_op_t op_kind = DAG_OP_NOP;
  logic [2:0] op_ptr = 3'h0;
  dag_mod_t op_mod = DAG_MOD_NONE;
  dag_swap_t op_swap = DAG_SWAP_ZERO_THEN_PLUS;
  logic [3:0] op_reg = 4'h0;
  logic [15:0] op_imm = 16'h0000;
  logic [4:0] op_offset = 5'h00;
  logic [15:0] op_wdata = 16'h0000;
  logic [3:0] peek_sel = 4'h0;
  logic op_ready, mem_req, mem_we, mem_xspace, ext_wr, modulo_active;
  logic [15:0] mem_rdata, mem_addr, mem_wdata, ext_wdata, peek_data, v;
  logic [3:0] ext_sel;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] lfsr = 16'h000A;
  logic [15:0] rf [0:15];
  logic [15:0] shadow [logic [16:0]];
  always #12.5 clk_sys = ~clk_sys;
  dag_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind),
    .op_ptr(op_ptr), .op_mod(op_mod), .op_swap(op_swap), .op_reg(op_reg), .op_imm(op_imm), .op_offset(op_offset),
    .op_wdata(op_wdata), .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_xspace(mem_xspace),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .ext_wr(ext_wr), .ext_sel(ext_sel), .ext_wdata(ext_wdata),
    .peek_sel(peek_sel), .peek_data(peek_data), .modulo_active(modulo_active));
  dag_mem_model mem (.clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we), .mem_xspace(mem_xspace),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      results();
    end
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic logic [15:0] rdexp(input logic [16:0] key);
    return shadow.exists(key) ? shadow[key] : (key[15:0] ^ 16'h5A3C);
  endfunction : rdexp
  // Wrap only when asked for a +1 step on a pointer sitting at the end address
  function automatic logic [15:0] nxt(input logic [15:0] p, input logic [15:0] d, input logic w);
    return (w && rf[`DAG_REG_RE] != 16'h0000 && p == rf[`DAG_REG_RE]) ? rf[`DAG_REG_RB] : p + d;
  endfunction : nxt
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Leaves op_valid high so a following op can run back to back; drop() ends a burst
  task automatic op(input dag_op_t k, input logic [2:0] p, input dag_mod_t m, input dag_swap_t s,
                    input logic [3:0] r, input logic [15:0] imm, input logic [15:0] wd);
    int n;
    n = 0;
    while (op_ready !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 20) chk("op_ready wait", 16'h0001, {15'h0, op_ready});
    op_kind = k;
    op_ptr = p;
    op_mod = m;
    op_swap = s;
    op_reg = r;
    op_imm = imm;
    op_wdata = wd;
    op_valid = 1'b1;
    @(negedge clk_sys);
  endtask : op
  task automatic drop();
    op_valid = 1'b0;
    @(negedge clk_sys);
  endtask : drop
  task automatic peek(input logic [3:0] c, input logic [15:0] exp);
    peek_sel = c;
    repeat (2) @(negedge clk_sys);
    chk("peek_data", exp, peek_data);
  endtask : peek
  task automatic ld(input logic [3:0] c, input logic [15:0] val);
    op(DAG_OP_IMM_LONG, 3'h0, DAG_MOD_NONE, DAG_SWAP_ZERO_THEN_PLUS, c, 16'h0000, 16'h0000);
    op(DAG_OP_NOP, 3'h0, DAG_MOD_NONE, DAG_SWAP_ZERO_THEN_PLUS, 4'h0, val, 16'h0000);
    chk("ext_wr", {15'h0, c >= 4'hB}, {15'h0, ext_wr});
    if (c >= 4'hB) begin
      chk("ext_sel", {12'h0, c}, {12'h0, ext_sel});
      chk("ext_wdata", val, ext_wdata);
    end else begin
      rf[c] = val;
    end
    drop();
  endtask : ld
  // Checks the access issued one cycle after acceptance and its load one cycle later
  task automatic fin(input logic w, input logic [16:0] key, input logic [3:0] r, input logic [15:0] d);
    chk("mem_req", 16'h0001, {15'h0, mem_req});
    chk("op_ready", {15'h0, w}, {15'h0, op_ready});
    chk("mem_we", {15'h0, w}, {15'h0, mem_we});
    chk("mem_xspace", {15'h0, key[16]}, {15'h0, mem_xspace});
    chk("mem_addr", key[15:0], mem_addr);
    if (w) begin
      chk("mem_wdata", d, mem_wdata);
      shadow[key] = d;
    end
    drop();
    chk("ext_wr", {15'h0, !w && r >= 4'hB}, {15'h0, ext_wr});
    if (!w && r >= 4'hB) begin
      chk("ext_wdata", rdexp(key), ext_wdata);
    end else if (!w) begin
      rf[r] = rdexp(key);
    end
  endtask : fin
  task automatic acc(input logic w, input logic [2:0] p, input dag_mod_t m, input logic [3:0] r);
    logic [15:0] a, wd, d;
    a = rf[p];
    wd = rnd();
    d = (r >= 4'hB) ? wd : rf[r];
    op(w ? DAG_OP_WR_IND : DAG_OP_RD_IND, p, m, DAG_SWAP_ZERO_THEN_PLUS, r, 16'h0000, wd);
    if (p == 3'h4) begin
      rf[4] = nxt(a, (m == DAG_MOD_STEP) ? rf[`DAG_REG_I] : 16'h0001, 1'b0);
    end else begin
      rf[p] = nxt(a, (m == DAG_MOD_NONE) ? 16'h0000 : (m == DAG_MOD_INC) ? 16'h0001 :
                     (m == DAG_MOD_DEC) ? 16'hFFFF : rf[`DAG_REG_J], m == DAG_MOD_INC);
    end
    fin(w, {p == 3'h4, a}, r, d);
    peek({1'b0, p}, rf[p]);
  endtask : acc
  task automatic swp(input logic [2:0] p, input dag_swap_t s, input logic [3:0] r);
    logic [15:0] a, t, wd, s2, s3;
    logic w2, w3;
    a = rf[p];
    wd = rnd();
    t = (r >= 4'hB) ? wd : rf[r];
    case (s)
      DAG_SWAP_ZERO_THEN_PLUS: {s2, s3, w2, w3} = {16'h0000, 16'h0001, 2'b01};
      DAG_SWAP_PLUS_THEN_ZERO: {s2, s3, w2, w3} = {16'h0001, 16'h0000, 2'b10};
      DAG_SWAP_MINUS_THEN_PLUS_TWO: {s2, s3, w2, w3} = {16'hFFFF, 16'h0002, 2'b00};
      default: {s2, s3, w2, w3} = {rf[`DAG_REG_J], rf[`DAG_REG_K], 2'b00};
    endcase
    op(DAG_OP_SWAP, p, DAG_MOD_NONE, s, r, 16'h0000, wd);
    rf[p] = nxt(a, s2, w2);
    fin(1'b0, {1'b0, a}, r, 16'h0000);
    chk("swap mem_req", 16'h0001, {15'h0, mem_req});
    chk("swap mem_we", 16'h0001, {15'h0, mem_we});
    chk("swap mem_addr", rf[p], mem_addr);
    chk("swap mem_wdata", t, mem_wdata);
    shadow[{1'b0, rf[p]}] = t;
    rf[p] = nxt(rf[p], s3, w3);
    peek({1'b0, p}, rf[p]);
    peek(r, rf[r]);
  endtask : swp
  task automatic dir(input logic w, input logic [3:0] r);
    logic [15:0] wd;
    wd = rnd();
    op_offset = wd[4:0];
    op(w ? DAG_OP_WR_DIR : DAG_OP_RD_DIR, 3'h0, DAG_MOD_NONE, DAG_SWAP_ZERO_THEN_PLUS, r, 16'h0000, wd);
    fin(w, {1'b0, rf[`DAG_REG_YBASE][15:5], wd[4:0]}, r, (r >= 4'hB) ? wd : rf[r]);
  endtask : dir
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    for (int c = 0; c < 16; c++) rf[c] = 16'h0000;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("modulo_active", 16'h0000, {15'h0, modulo_active});
    peek(`DAG_REG_RE, 16'h0000);
    // Back-to-back short loads; page base and outside codes must stay untouched
    for (int c = 0; c < 12; c++) begin
      v = rnd();
      op(DAG_OP_IMM_SHORT, 3'h0, DAG_MOD_NONE, DAG_SWAP_ZERO_THEN_PLUS, c[3:0], v, 16'h0000);
      chk("short mem_req", 16'h0000, {15'h0, mem_req});
      if (c < 10) rf[c] = {7'h00, v[8:0]};
    end
    drop();
    for (int c = 0; c < 12; c++) peek(c[3:0], rf[c]);
    for (int c = 0; c < 12; c++) ld(c[3:0], rnd());
    for (int c = 0; c < 12; c++) peek(c[3:0], rf[c]);
    for (int n = 0; n < 40; n++) begin
      v = rnd();
      acc(v[0], v[3:1] % 3'h5, dag_mod_t'(v[5:4]), v[0] ? v[9:6] : 4'hB + {1'b0, v[8:6] % 3'h5});
    end
    ld(`DAG_REG_RB, 16'h0100);
    ld(`DAG_REG_RE, 16'h0103);
    ld(`DAG_REG_J, 16'h0001);
    chk("modulo_active", 16'h0001, {15'h0, modulo_active});
    ld(4'h1, 16'h0103);
    acc(1'b0, 3'h1, DAG_MOD_INC, 4'hB);
    peek(4'h1, 16'h0100);
    ld(4'h1, 16'h0103);
    acc(1'b0, 3'h1, DAG_MOD_DEC, 4'hC);
    peek(4'h1, 16'h0102);
    ld(4'h1, 16'h0103);
    acc(1'b1, 3'h1, DAG_MOD_STEP, 4'hD);
    peek(4'h1, 16'h0104);
    ld(4'h4, 16'h0103);
    acc(1'b0, 3'h4, DAG_MOD_INC, 4'hE);
    peek(4'h4, 16'h0104);
    acc(1'b1, 3'h4, DAG_MOD_STEP, 4'hF);
    for (int s = 0; s < 4; s++) begin
      ld(4'h2, 16'h0103);
      swp(3'h2, dag_swap_t'(s), 4'hB);
    end
    swp(3'h0, DAG_SWAP_MINUS_THEN_PLUS_TWO, 4'h3);
    swp(3'h1, DAG_SWAP_STEPREG_PAIR, 4'h4);
    ld(`DAG_REG_RE, 16'h0000);
    chk("modulo_active", 16'h0000, {15'h0, modulo_active});
    ld(4'h1, 16'h0103);
    acc(1'b0, 3'h1, DAG_MOD_INC, 4'hB);
    peek(4'h1, 16'h0104);
    ld(4'h0, 16'hFFFF);
    acc(1'b1, 3'h0, DAG_MOD_INC, 4'h5);
    peek(4'h0, 16'h0000);
    acc(1'b1, 3'h0, DAG_MOD_DEC, 4'h6);
    peek(4'h0, 16'hFFFF);
    ld(`DAG_REG_YBASE, rnd());
    for (int n = 0; n < 8; n++) begin
      v = rnd();
      dir(v[0], v[1] ? 4'hF : 4'h5);
    end
    results();
  end
endmodule : tb_data_address_generation
`default_nettype wire
